/* File: hdl/rom_card_decoder.sv */
// Bank, section and socket decode for a plug-in read-only memory card.
// Assumes bus pins are asynchronous to mclk; switches are static levels.
// Notes on behaviour
// - Read data leaves the card as eight inverted bits.
// - Phase 2 clock and read/write are taken in and inverted internally.
// - Card drives an active-low responding indication onto the bus.
// - Bank match compares bank line with bank-select switches.
// - With enable set, one 8K half answers in both banks.
// - Four comparators each place a 4K section on any 4K boundary.
// - A matching comparator enables chip-select generation.
// - Selects come from bank, section, device size and low address.
// - Type setting steers each select to the expected socket pin.
// - Data buffers drive only on a matched read.
// - Eight sockets cover up to 16K bytes.
module rom_card_decoder #(
  parameter int SOCKETS = rom_card_pkg::SOCKETS
) (
  input  wire logic                                   mclk,
  input  wire logic                                   nrst,
  input  wire logic [rom_card_pkg::ADDR_W-1:0]        addr_n,
  input  wire logic                                   bank_line_n,
  input  wire logic                                   read_not_write,
  input  wire logic                                   phase2,
  input  wire logic                                   bank_sel,
  input  wire logic                                   bank_sel_en,
  input  wire logic [rom_card_pkg::SECTIONS*rom_card_pkg::BASE_W-1:0] base_sw,
  input  wire logic [1:0]                             dev_size,
  input  wire logic [SOCKETS-1:0]                     dev_type,
  output logic      [rom_card_pkg::DATA_W-1:0]        rd_data_n,
  output logic      [rom_card_pkg::DATA_W-1:0]        data_n_oe,
  output logic                                        card_responding_n,
  output logic      [SOCKETS-1:0]                     sel_pin_a_n,
  output logic      [SOCKETS-1:0]                     sel_pin_b_n
);
  localparam int AW = rom_card_pkg::ADDR_W;
  localparam int DW = rom_card_pkg::DATA_W;
  localparam int NS = rom_card_pkg::SECTIONS;
  localparam int BW = rom_card_pkg::BASE_W;

  // Socket decode function is written for eight sockets only
  generate
    if (SOCKETS != rom_card_pkg::SOCKETS) begin : g_bad_sockets
      $error("socket count must be eight");
    end
  endgenerate

  // Reset release through two stages
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Two-stage synchronisers on all bus pins
  localparam int PW = AW + 3;
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      // Idle levels: address, bank and read high, phase 2 low, so no false read
      pin_s1_r <= {{(AW+2){1'b1}}, 1'b0};
      pin_s2_r <= {{(AW+2){1'b1}}, 1'b0};
    end else begin
      pin_s1_r <= {addr_n, bank_line_n, read_not_write, phase2};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Switches are pins as well; a jumper moved in service must not glitch a decode
  localparam int SW = 2 + NS*BW + 2 + SOCKETS;
  logic [SW-1:0]      sw_s1_r;
  logic [SW-1:0]      sw_s2_r;
  logic               sw_bank_sel;
  logic               sw_bank_en;
  logic [NS*BW-1:0]   sw_base;
  logic [1:0]         sw_size;
  logic [SOCKETS-1:0] sw_type;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sw_s1_r <= '0;
      sw_s2_r <= '0;
    end else begin
      sw_s1_r <= {bank_sel, bank_sel_en, base_sw, dev_size, dev_type};
      sw_s2_r <= sw_s1_r;
    end
  end
  assign {sw_bank_sel, sw_bank_en, sw_base, sw_size, sw_type} = sw_s2_r;

  logic          phase2_n_int;
  logic          write_int;
  logic          phase2_int;
  logic          rd_int;
  logic [AW-1:0] addr;
  logic          bank;
  assign phase2_n_int = ~pin_s2_r[0];
  assign write_int    = ~pin_s2_r[1];
  assign phase2_int   = ~phase2_n_int;
  assign rd_int       = ~write_int;
  assign bank         = ~pin_s2_r[2];
  assign addr         = ~pin_s2_r[PW-1 -: AW];

  // bank match per 8K half; common half when enabled
  logic half_common_ok;
  logic half_bank_ok;
  assign half_bank_ok   = (bank == sw_bank_sel);
  assign half_common_ok = sw_bank_en ? 1'b1 : half_bank_ok;

  logic [NS-1:0] sect_hit;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sect
      section_match #(
        .ADDR_W (AW),
        .BASE_W (BW)
      ) u_sect (
        .addr    (addr),
        .base    (sw_base[g*BW +: BW]),
        .bank_ok ((g < NS/2) ? half_common_ok : half_bank_ok),
        .hit     (sect_hit[g])
      );
    end
  endgenerate

  // socket index from section, size and low address
  function automatic logic [SOCKETS-1:0] socket_dec(
    input logic [NS-1:0] hit,
    input logic [1:0]    size,
    input logic [AW-1:0] a
  );
    logic [SOCKETS-1:0] s;
    s = '0;
    for (int k = 0; k < NS; k++) begin
      if (hit[k]) begin
        if (size == rom_card_pkg::SIZE_2K) begin
          s[2*k + int'(a[11])] = 1'b1;
        end else if (size == rom_card_pkg::SIZE_4K) begin
          s[2*k] = 1'b1;
        end else begin
          s[4*(k/2)] = 1'b1;
        end
      end
    end
    return s;
  endfunction

  logic any_hit;
  logic [SOCKETS-1:0] sock_sel;
  assign any_hit  = |sect_hit;
  assign sock_sel = socket_dec(sect_hit, sw_size, addr);

  logic [10:0] rom_off;
  logic [DW-1:0] rom_data;
  // eight sockets, 2K slices, 16K total
  rom_store #(
    .SOCKETS (SOCKETS),
    .DEPTH   (rom_card_pkg::TOTAL_BYTES / SOCKETS),
    .DATA_W  (DW)
  ) u_store (
    .mclk   (mclk),
    .sel    (sock_sel),
    .offset (rom_off),
    .rdata  (rom_data)
  );
  assign rom_off = addr[10:0];

  // Cycle sequencing: the store's registered data lags one edge
  rom_card_pkg::cyc_state_t st_r;
  rom_card_pkg::cyc_state_t st_nxt;
  logic          match_rd;
  logic [DW-1:0] data_n_nxt;
  logic [DW-1:0] oe_nxt;
  logic          resp_n_nxt;
  logic [SOCKETS-1:0] sel_a_nxt;
  logic [SOCKETS-1:0] sel_b_nxt;

  // writes never match
  // Phase 2 taken as a level; the bus clock is far slower than mclk
  assign match_rd = any_hit && rd_int && phase2_int;

  always_comb begin
    st_nxt     = st_r;
    data_n_nxt = {DW{1'b1}};
    oe_nxt     = '0;
    resp_n_nxt = 1'b1;
    sel_a_nxt  = {SOCKETS{1'b1}};
    sel_b_nxt  = {SOCKETS{1'b1}};
    // IDLE waits one edge for the store's registered byte; FETCH already drives it
    case (st_r)
      rom_card_pkg::ST_IDLE: begin
        if (match_rd) begin
          st_nxt = rom_card_pkg::ST_FETCH;
        end
      end
      rom_card_pkg::ST_FETCH: begin
        st_nxt = match_rd ? rom_card_pkg::ST_DRIVE : rom_card_pkg::ST_IDLE;
      end
      rom_card_pkg::ST_DRIVE: begin
        if (!match_rd) begin
          st_nxt = rom_card_pkg::ST_IDLE;
        end
      end
      default: st_nxt = rom_card_pkg::ST_IDLE;
    endcase
    if (match_rd) begin
      for (int s = 0; s < SOCKETS; s++) begin
        if (sw_type[s] == rom_card_pkg::TYPE_SEL_B) begin
          sel_b_nxt[s] = ~sock_sel[s];
        end else begin
          sel_a_nxt[s] = ~sock_sel[s];
        end
      end
    end
    if (match_rd && st_r != rom_card_pkg::ST_IDLE) begin
      data_n_nxt = ~rom_data;
      oe_nxt     = {DW{1'b1}};
      resp_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r              <= rom_card_pkg::ST_IDLE;
      rd_data_n         <= {DW{1'b1}};
      data_n_oe         <= '0;
      card_responding_n <= 1'b1;
      sel_pin_a_n       <= {SOCKETS{1'b1}};
      sel_pin_b_n       <= {SOCKETS{1'b1}};
    end else begin
      st_r              <= st_nxt;
      rd_data_n         <= data_n_nxt;
      data_n_oe         <= oe_nxt;
      card_responding_n <= resp_n_nxt;
      sel_pin_a_n       <= sel_a_nxt;
      sel_pin_b_n       <= sel_b_nxt;
    end
  end

  // Responding and buffers share one condition; a split would fight the bus
  resp_oe_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (!card_responding_n) == (&data_n_oe))
    else $error("responding differs from enable");
  write_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    write_int |=> data_n_oe == '0)
    else $error("data driven during write");
  write_nosel_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    write_int |=> (&sel_pin_a_n) && (&sel_pin_b_n))
    else $error("socket selected during write");
  drive_hit_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    !any_hit |=> !card_responding_n == 1'b0)
    else $error("drive without decode");
  data_inv_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (match_rd && st_r != rom_card_pkg::ST_IDLE) |=> rd_data_n == ~$past(rom_data))
    else $error("data not inverted");
  one_sock_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    $onehot0(~(sel_pin_a_n & sel_pin_b_n)))
    else $error("two sockets selected");
  sock_hit_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    match_rd |=> !(&(sel_pin_a_n & sel_pin_b_n)))
    else $error("matched read selects no socket");
  // Selects lag the type switch by one edge
  type_steer_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (((~sel_pin_a_n) & $past(sw_type)) | ((~sel_pin_b_n) & ~$past(sw_type))) == '0)
    else $error("select on wrong socket pin");

  // Decode checks
  common_half_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (sw_bank_en && addr[AW-1 -: BW] == sw_base[BW-1:0]) |-> sect_hit[0])
    else $error("common half not matched");
  bank_half_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    sect_hit[NS-1] |-> bank == sw_bank_sel)
    else $error("banked half wrong bank");
  base_place_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (addr[AW-1 -: BW] == sw_base[NS*BW-1 -: BW] && bank == sw_bank_sel) |-> sect_hit[NS-1])
    else $error("section base not matched");

  // Timing checks
  resp_time_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    match_rd [*3] |-> !card_responding_n)
    else $error("no response on steady read");
  resp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    (!card_responding_n && match_rd) |=> !card_responding_n)
    else $error("response dropped during read");
  idle_phase_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
    !phase2_int |=> card_responding_n)
    else $error("response outside phase 2");
endmodule

/* File: hdl/rom_card_pkg.sv */
// Constants shared by the memory card decoder files.
// Assumes a single 100 MHz clock domain.
package rom_card_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam int          SOCKETS       = 8;
  localparam int          SECTIONS      = 4;
  localparam int          SECT_SHIFT    = 12;
  localparam int          BASE_W        = 4;
  localparam int          TOTAL_BYTES   = 16384;
  localparam logic [1:0]  SIZE_2K       = 2'h0;
  localparam logic [1:0]  SIZE_4K       = 2'h1;
  localparam logic [1:0]  SIZE_8K       = 2'h2;
  localparam logic        TYPE_SEL_A    = 1'h0;
  localparam logic        TYPE_SEL_B    = 1'h1;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          ACCESS_NS     = 450;
  localparam int          ACCESS_CYC    = ACCESS_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_DRIVE = 2'h2
  } cyc_state_t;
endpackage

/* File: hdl/rom_store.sv */
// Eight-socket read-only store, 2 KB per socket slice.
// Assumes same-clock select and offset; read data out of a register.
module rom_store #(
  parameter int SOCKETS = 8,
  parameter int DEPTH   = 2048,
  parameter int DATA_W  = 8
) (
  input  wire logic                       mclk,
  input  wire logic [SOCKETS-1:0]         sel,
  input  wire logic [$clog2(DEPTH)-1:0]   offset,
  output logic      [DATA_W-1:0]          rdata
);
  // A depth that is not a power of two would spill into the next socket
  generate
    if (DEPTH != 2**$clog2(DEPTH)) begin : g_bad_depth
      $error("store depth must be a power of two");
    end
  endgenerate
  logic [DATA_W-1:0] mem [SOCKETS*DEPTH];
  logic [DATA_W-1:0] rdata_nxt;
  initial begin
    for (int i = 0; i < SOCKETS*DEPTH; i++) begin
      mem[i] = DATA_W'(i);
    end
  end
  always_comb begin
    rdata_nxt = '0;
    for (int s = 0; s < SOCKETS; s++) begin
      if (sel[s]) begin
        rdata_nxt = mem[s*DEPTH + int'(offset)];
      end
    end
  end
  always_ff @(posedge mclk) begin
    rdata <= rdata_nxt;
  end
endmodule

/* File: hdl/section_match.sv */
// One 4K section comparator.
// Assumes active-high address from the same clock domain.
module section_match #(
  parameter int ADDR_W = 16,
  parameter int BASE_W = 4
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [BASE_W-1:0] base,
  input  wire logic              bank_ok,
  output logic                   hit
);
  generate
    if (BASE_W > ADDR_W) begin : g_bad_base
      $error("base wider than address");
    end
  endgenerate
  assign hit = bank_ok && (addr[ADDR_W-1 -: BASE_W] == base);
endmodule

/* File: verif/bus_master_model.sv */
// Behavioural backplane master for the memory card decoder.
// Assumes the bench calls drive and idle; pins change at falling mclk.
module bus_master_model (
  input  wire logic        mclk,
  output logic      [15:0] addr_n,
  output logic             bank_line_n,
  output logic             read_not_write,
  output logic             phase2
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_n         = 16'hFFFF;
    bank_line_n    = 1'h1;
    read_not_write = 1'h1;
    phase2         = 1'h0;
  end

  task automatic drive(input logic [15:0] a, input logic bank, input logic rd,
                       input logic p2);
    @(negedge mclk);
    addr_n         <= ~a;
    bank_line_n    <= ~bank;
    read_not_write <= rd;
    phase2         <= p2;
  endtask

  // Released lines show the inverse so stale decode cannot pass
  task automatic idle();
    @(negedge mclk);
    addr_n         <= ~addr_n;
    bank_line_n    <= ~bank_line_n;
    read_not_write <= 1'h1;
    phase2         <= 1'h0;
  endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the memory card decoder.
// Assumes store byte equals low address byte; switches change only between accesses.
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t: got %h want %h", $time, act, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'h0;
  logic        nrst = 1'h0;
  logic        bank_sel = 1'h0;
  logic        bank_sel_en = 1'h1;
  logic [15:0] base_sw = 16'hDCBA;
  logic [1:0]  dev_size = rom_card_pkg::SIZE_2K;
  logic [7:0]  dev_type = 8'hA5;
  wire  [15:0] addr_n;
  wire         bank_line_n;
  wire         read_not_write;
  wire         phase2;
  wire  [7:0]  rd_data_n;
  wire  [7:0]  data_n_oe;
  wire         card_responding_n;
  wire  [7:0]  sel_pin_a_n;
  wire  [7:0]  sel_pin_b_n;
  int          error_cnt = 0;
  int          num_checks = 0;

  bus_master_model bus_master_model_i (.mclk(mclk), .addr_n(addr_n),
    .bank_line_n(bank_line_n), .read_not_write(read_not_write), .phase2(phase2));

  rom_card_decoder rom_card_decoder_i (.mclk(mclk), .nrst(nrst), .addr_n(addr_n),
    .bank_line_n(bank_line_n), .read_not_write(read_not_write), .phase2(phase2),
    .bank_sel(bank_sel), .bank_sel_en(bank_sel_en), .base_sw(base_sw),
    .dev_size(dev_size), .dev_type(dev_type), .rd_data_n(rd_data_n),
    .data_n_oe(data_n_oe), .card_responding_n(card_responding_n),
    .sel_pin_a_n(sel_pin_a_n), .sel_pin_b_n(sel_pin_b_n));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One access held long enough for data, then judged and released
  task automatic acc(input logic [15:0] a, input logic bank, input logic rd,
                     input logic p2, input logic hit, input int s);
    logic [7:0] m;
    m = hit ? (8'h01 << s) : 8'h00;
    bus_master_model_i.drive(a, bank, rd, p2);
    repeat (6) @(posedge mclk);
    #1;
    `CHK(sel_pin_a_n, ~(m & ~dev_type))
    `CHK(sel_pin_b_n, ~(m & dev_type))
    `CHK(data_n_oe, hit ? 8'hFF : 8'h00)
    `CHK(card_responding_n, ~hit)
    `CHK(rd_data_n, hit ? ~a[7:0] : 8'hFF)
    bus_master_model_i.idle();
    repeat (5) @(posedge mclk);
  endtask

  // Every section and half with 2K parts reaches all eight sockets
  task automatic t_sections();
    logic [15:0] a;
    dev_size = rom_card_pkg::SIZE_2K;
    for (int k = 0; k < 4; k++) begin
      for (int h = 0; h < 2; h++) begin
        a = (16'(4'hA + k) << 12) | 16'(h << 11) | 16'(8'h30 + 2 * k + h);
        acc(a, 1'h0, 1'h1, 1'h1, 1'h1, 2 * k + h);
      end
    end
    acc(16'h1234, 1'h0, 1'h1, 1'h1, 1'h0, 0);
  endtask

  // Larger parts fold sections onto fewer sockets
  task automatic t_sizes();
    @(negedge mclk);
    dev_size = rom_card_pkg::SIZE_4K;
    acc(16'hD812, 1'h0, 1'h1, 1'h1, 1'h1, 6);
    @(negedge mclk);
    dev_size = rom_card_pkg::SIZE_8K;
    acc(16'hDF47, 1'h0, 1'h1, 1'h1, 1'h1, 4);
    acc(16'hB0C9, 1'h0, 1'h1, 1'h1, 1'h1, 0);
    @(negedge mclk);
    dev_size = rom_card_pkg::SIZE_2K;
  endtask

  // Common half versus banked half
  task automatic t_bank();
    acc(16'hA055, 1'h1, 1'h1, 1'h1, 1'h1, 0);
    acc(16'hC066, 1'h1, 1'h1, 1'h1, 1'h0, 0);
    acc(16'hC077, 1'h0, 1'h1, 1'h1, 1'h1, 4);
    @(negedge mclk);
    bank_sel_en = 1'h0;
    bank_sel    = 1'h1;
    acc(16'hA088, 1'h0, 1'h1, 1'h1, 1'h0, 0);
    acc(16'hA099, 1'h1, 1'h1, 1'h1, 1'h1, 0);
    acc(16'hC0AA, 1'h1, 1'h1, 1'h1, 1'h1, 4);
    acc(16'hC0BB, 1'h0, 1'h1, 1'h1, 1'h0, 0);
  endtask

  // Writes and reads outside phase 2 leave the bus alone
  task automatic t_refuse();
    acc(16'hA0CC, 1'h1, 1'h0, 1'h1, 1'h0, 0);
    acc(16'hA0DD, 1'h1, 1'h1, 1'h0, 1'h0, 0);
  endtask

  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'h1;
    repeat (3) @(posedge mclk);
    t_sections();
    t_sizes();
    t_bank();
    t_refuse();
    report_and_stop();
  end
endmodule
